/* tb/vfd_output_assign_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module vfd_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // memory side
  input wire logic mem_wr_i,
  input wire logic mem_hit_o,
  input wire logic [15:0] mem_addr_i,
  input wire vfd_pkg::vfd_byte_t mem_wdata_i,
  input wire vfd_pkg::vfd_byte_t mem_rdata_o,
  // mode and lines
  input wire vfd_pkg::vfd_byte_t mode_a_rdata_o,
  input wire vfd_pkg::vfd_byte_t mode_b_rdata_o,
  input wire logic key_scan_flag_o,
  input wire logic [52:13] port_latch_i,
  input wire vfd_pkg::vfd_lines_t line_o,
  input wire vfd_pkg::vfd_lines_t line_is_display_o
);
  import vfd_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [11:0] ks_cnt_reg;
  // slot length counter; 12 bits so the long 2048 cycle still fits
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) ks_cnt_reg <= 12'h000;
    else if (clk_en_i)
      ks_cnt_reg <= key_scan_flag_o ? ks_cnt_reg + 12'h001 : 12'h000;
  end
  sequence s_ks2;
    key_scan_flag_o ##1 key_scan_flag_o;
  endsequence
  sequence s_wr;
    mem_wr_i && mem_hit_o ##1 !mem_wr_i && $stable(mem_addr_i);
  endsequence
  property p_ks_dark;
    s_ks2 |-> line_o[12:0] == 13'h0 && line_is_display_o == 53'h0;
  endproperty
  property p_ks_port;
    s_ks2 |-> line_o[52:13] == $past(port_latch_i);
  endproperty
  property p_ks_len;
    $fell(key_scan_flag_o) |->
      ks_cnt_reg == (mode_b_rdata_o[0] ? 12'h800 : 12'h400);
  endproperty
  property p_flag;
    mode_a_rdata_o[7] == key_scan_flag_o;
  endproperty
  property p_stop;
    (mode_b_rdata_o[7:4] == 4'h0)[*3] |-> line_is_display_o == 53'h0
      && line_o == {$past(port_latch_i), 13'h0};
  endproperty
  property p_start;
    (mode_b_rdata_o[7:4] == 4'h0)[*3] ##1 mode_b_rdata_o[7:4] != 4'h0 |->
      ##2 (line_is_display_o != 53'h0 &&
           (line_o & line_is_display_o) == 53'h0)[*8];
  endproperty
  property p_hit;
    mem_hit_o == (mem_addr_i >= 16'hfa30 && mem_addr_i <= 16'hfa7f);
  endproperty
  property p_rw;
    s_wr |=> mem_rdata_o == $past(mem_wdata_i, 2);
  endproperty
  a_ks_dark: assert property (p_ks_dark)
    else $error("lines lit in key scan");
  a_ks_port: assert property (p_ks_port)
    else $error("port data lost");
  a_ks_len: assert property (p_ks_len)
    else $error("key scan length");
  a_flag: assert property (p_flag)
    else $error("flag bit wrong");
  a_stop: assert property (p_stop)
    else $error("stopped lines not ports");
  a_start: assert property (p_start)
    else $error("start cycle not dark");
  a_hit: assert property (p_hit)
    else $error("memory window wrong");
  a_rw: assert property (p_rw)
    else $error("memory read back wrong");
endmodule : vfd_chk
bind vfd_output_assign vfd_chk u_chk (
  .clk_i(clk_i),
  .rst_b_i(rst_b_i),
  .clk_en_i(clk_en_i),
  .mem_wr_i(mem_wr_i),
  .mem_hit_o(mem_hit_o),
  .mem_addr_i(mem_addr_i),
  .mem_wdata_i(mem_wdata_i),
  .mem_rdata_o(mem_rdata_o),
  .mode_a_rdata_o(mode_a_rdata_o),
  .mode_b_rdata_o(mode_b_rdata_o),
  .key_scan_flag_o(key_scan_flag_o),
  .port_latch_i(port_latch_i),
  .line_o(line_o),
  .line_is_display_o(line_is_display_o)
);
`default_nettype wire

/* tb/vfd_output_assign_test.sv */
`timescale 1ns/1ps
`default_nettype none
module vfd_output_assign_test;
  import vfd_pkg::*;
  localparam logic [39:0] SEG0 = 40'h81c33c01a5;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wa = 1'b0, wb = 1'b0, wc = 1'b0, mwr = 1'b0;
  vfd_byte_t wd = 8'h00, md = 8'h00, ra, rb, rc, mrd;
  logic [15:0] ma = 16'h0000;
  logic key_scan_flag, hit;
  logic [52:13] pl;
  vfd_lines_t ln, dsp;
  int miscompares = 0, n_compared = 0, i;
  always #20 clk_i = ~clk_i;
  vfd_output_assign DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
    .mode_a_wr_i(wa), .mode_b_wr_i(wb), .mode_c_wr_i(wc),
    .mode_wdata_i(wd), .mode_a_rdata_o(ra), .mode_b_rdata_o(rb),
    .mode_c_rdata_o(rc), .key_scan_flag_o(key_scan_flag), .mem_addr_i(ma),
    .mem_wr_i(mwr), .mem_wdata_i(md), .mem_rdata_o(mrd), .mem_hit_o(hit),
    .port_latch_i(pl), .line_o(ln), .line_is_display_o(dsp));
  vfd_panel_model PM (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .key_scan_flag_i(key_scan_flag), .port_latch_o(pl));
  // shared compare; case equality, so an unknown matches only an unknown
  task automatic chk(input logic [52:0] seen, input logic [52:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // register write: 0 selects a, 1 b, 2 c
  task automatic wr(input int r, input vfd_byte_t d);
    @(negedge clk_i);
    wd = d;
    wa = (r == 0);
    wb = (r == 1);
    wc = (r == 2);
    @(negedge clk_i);
    {wa, wb, wc} = 3'h0;
  endtask : wr
  task automatic mw(input logic [15:0] a, input vfd_byte_t d);
    @(negedge clk_i);
    ma = a;
    md = d;
    mwr = 1'b1;
    @(negedge clk_i);
    mwr = 1'b0;
  endtask : mw
  task automatic mr(input logic [15:0] a, input vfd_byte_t e);
    @(negedge clk_i);
    ma = a;
    @(negedge clk_i);
    chk(mrd, e);
  endtask : mr
  // bounded wait on the flag; counts cycles in i
  task automatic wks(input logic v);
    i = 0;
    while (key_scan_flag !== v) begin
      @(negedge clk_i);
      i++;
      if (i > 40000) begin
        miscompares++;
        end_of_test();
      end
    end
  endtask : wks
  task automatic t_reset;
    @(negedge clk_i);
    chk({ra, rb, rc, key_scan_flag}, 25'h0);
    chk(dsp, 53'h0);
    chk(ln, {pl, 13'h0});
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs;
    wr(0, 8'hff);
    chk(ra, 8'h7f);
    wr(2, 8'hff);
    chk(rc, 8'h3f);
    wr(0, 8'h20);
    chk(ra, 8'h20);
    $display("test regs done");
  endtask : t_regs
  task automatic t_mem;
    for (int k = 0; k < 5; k++)
      mw(16'hfa30 + 16'(k * 16), SEG0[k*8+:8]);
    mw(16'hfa7f, 8'h5a);
    mr(16'hfa7f, 8'h5a);
    mw(16'hfa80, 8'hff);
    mr(16'hfa80, 8'h00);
    chk(hit, 1'b0);
    mr(16'hfa2f, 8'h00);
    mr(16'hfa30, SEG0[7:0]);
    $display("test memory done");
  endtask : t_mem
  // two digits, nine segments, short cycle, full frame
  task automatic t_disp1;
    wr(0, 8'h00);
    wr(1, 8'h10);
    repeat (2) @(negedge clk_i);
    chk(dsp, 53'h7ff);
    chk(ln & dsp, 53'h0);
    repeat (1024) @(negedge clk_i);
    chk(ln, {pl, 2'b00, SEG0[8:0], 2'b01});
    chk(dsp, 53'h7ff);
    repeat (1024) @(negedge clk_i);
    chk(ln[1:0], 2'b10);
    wks(1'b1);
    @(negedge clk_i);
    chk(ln[12:0], 13'h0);
    chk(ln[44:13], pl[44:13]);
    wks(1'b0);
    chk(i, 1023);
    repeat (2) @(negedge clk_i);
    chk(ln[1:0], 2'b01);
    wr(1, 8'h00);
    repeat (3) @(negedge clk_i);
    chk(dsp, 53'h0);
    $display("test mode one done");
  endtask : t_disp1
  // sixteen patterns, 40 outputs asked, long cycle
  task automatic t_disp2;
    wr(0, 8'h3f);
    wr(1, 8'hf1);
    repeat (2) @(negedge clk_i);
    chk(dsp, {53{1'b1}});
    repeat (2048) @(negedge clk_i);
    chk(ln, {13'h0, SEG0});
    wks(1'b1);
    wks(1'b0);
    chk(i, 2048);
    wr(1, 8'h00);
    $display("test mode two done");
  endtask : t_disp2
  initial begin
    repeat (3) @(negedge clk_i);
    rst_b_i = 1'b1;
    t_reset();
    t_regs();
    t_mem();
    t_disp1();
    t_disp2();
    end_of_test();
  end
endmodule : vfd_output_assign_test
`default_nettype wire

/* tb/vfd_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vfd_panel_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // key scan slot and port latches
  input wire logic key_scan_flag_i,
  output logic [52:13] port_latch_o
);
  logic [7:0] scan_reg;
  // key matrix walk: one column a clock on ports 45 to 52 during the slot only
  // other ports stay put, so no segment and digit pair lights together
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) scan_reg <= 8'h01;
    else if (key_scan_flag_i) scan_reg <= {scan_reg[6:0], scan_reg[7]};
  end
  assign port_latch_o = {scan_reg, 32'hc3a55a3c};
endmodule : vfd_panel_model
`default_nettype wire

/* verilog/vfd_disp_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vfd_regs.svh"

module vfd_disp_mem (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // processor side
  input wire logic [15:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire vfd_pkg::vfd_byte_t cpu_wdata_i,
  output vfd_pkg::vfd_byte_t cpu_rdata_o,
  output logic cpu_hit_o,
  // display fetch side
  input wire vfd_pkg::vfd_digit_t dma_digit_i,
  output vfd_pkg::vfd_seg_word_t dma_word_o
);
  import vfd_pkg::*;

  logic [7:0] mem [0:`VFD_MEM_WORDS-1];
  logic [15:0] off_full;
  logic [6:0] idx;

  // window decode; bytes outside the window are simply not ours
  assign cpu_hit_o = (cpu_addr_i >= `VFD_MEM_BASE) &&
                     (cpu_addr_i <= `VFD_MEM_LAST);
  assign off_full = cpu_addr_i - `VFD_MEM_BASE;
  assign idx = off_full[6:0];

  // plain ram for software; no reset so it maps onto a memory macro
  always_ff @(posedge clk_i) begin
    if (clk_en_i && cpu_wr_i && cpu_hit_o) begin
      mem[idx] <= cpu_wdata_i;
    end
  end

  // processor read data, registered
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      cpu_rdata_o <= cpu_hit_o ? mem[idx] : 8'h00;
    end
  end

  // own read port: the fetch never waits on the processor
  genvar b;
  generate
    for (b = 0; b < 5; b = b + 1) begin : g_bank
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          dma_word_o[8*b +: 8] <= 8'h00;
        end else if (clk_en_i) begin
          dma_word_o[8*b +: 8] <= mem[{3'(b), dma_digit_i}];
        end
      end
    end
  endgenerate

endmodule : vfd_disp_mem
`default_nettype wire

/* verilog/vfd_output_assign.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vfd_regs.svh"

// Overview of operation
// - lines from 0 carry digits first, then segments, per mode regs a and b.
// - lines 13 to 52 not given to digits or segments behave as general ports; unused lines 0 to 12 stay 0.
// - digits numbered from 0, at most 16; segments follow the last digit.
// - display memory sits in the window fa30 to fa7f.
// - segment data is fetched by the controller itself, not the processor.
// - unused display memory bytes work as normal read/write ram.
// - in key scan all display outputs are 0; port latches drive shared lines.
// - key scan flag is 1 in key scan and clears itself otherwise.
// - key scan flag is bit 7 of mode register a, read only.
// - port data shows on lines 13 to 52 during key scan.
// - bit 5 of mode register a picks display mode 1 or mode 2.
// - in mode 1 memory holds segment data read per digit.
// - digit field 0 stops display; n gives n+1 digits or patterns.
// - when digits plus segments pass 53 lines, segments are cut.
// - key scan slot lasts one display cycle of 1024 or 2048 clocks.
// - starting from stop, all display outputs are 0 for one cycle.
module vfd_output_assign (
  // clock, enable and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // mode register writes
  input wire logic mode_a_wr_i,
  input wire logic mode_b_wr_i,
  input wire logic mode_c_wr_i,
  input wire vfd_pkg::vfd_byte_t mode_wdata_i,
  // mode register read back
  output vfd_pkg::vfd_byte_t mode_a_rdata_o,
  output vfd_pkg::vfd_byte_t mode_b_rdata_o,
  output vfd_pkg::vfd_byte_t mode_c_rdata_o,
  output logic key_scan_flag_o,
  // display memory access from the processor
  input wire logic [15:0] mem_addr_i,
  input wire logic mem_wr_i,
  input wire vfd_pkg::vfd_byte_t mem_wdata_i,
  output vfd_pkg::vfd_byte_t mem_rdata_o,
  output logic mem_hit_o,
  // port output latches of the shared lines 13 to 52
  input wire logic [52:13] port_latch_i,
  // display output lines
  output vfd_pkg::vfd_lines_t line_o,
  output vfd_pkg::vfd_lines_t line_is_display_o
);
  import vfd_pkg::*;

  // mode registers
  vfd_byte_t mode_a_reg;
  vfd_byte_t mode_b_reg;
  vfd_byte_t mode_c_reg;

  // sequencer state
  vfd_state_t state_reg;
  logic [10:0] cyc_cnt_reg;
  vfd_digit_t digit_reg;
  vfd_seg_word_t seg_word_reg;

  // derived configuration
  logic [3:0] digs;
  logic running;
  logic mode2;
  logic [10:0] cyc_last;
  logic cyc_term;
  logic [5:0] ndig;
  logic [5:0] nseg_raw;
  logic [5:0] nseg_room;
  logic [5:0] nseg;
  logic [6:0] disp_end;
  vfd_digit_t fetch_digit;
  vfd_seg_word_t fetch_word;

  // next values of the output lines
  vfd_lines_t line_next;
  vfd_lines_t disp_next;

  // mode register a: bit 7 is the live flag and cannot be written
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_a_reg <= `VFD_A_RST;
    end else if (clk_en_i && mode_a_wr_i) begin
      mode_a_reg <= {1'b0, mode_wdata_i[6:0]};
    end
  end

  // mode register b: digit count, cut width, cycle length
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_b_reg <= `VFD_B_RST;
    end else if (clk_en_i && mode_b_wr_i) begin
      mode_b_reg <= mode_wdata_i;
    end
  end

  // mode register c: mask count, upper two bits read as zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_c_reg <= `VFD_C_RST;
    end else if (clk_en_i && mode_c_wr_i) begin
      mode_c_reg <= {2'b00, mode_wdata_i[`VFD_C_MASK]};
    end
  end

  // read back; the flag follows the sequencer, not software
  assign key_scan_flag_o = (state_reg == vfd_st_keyscan);
  assign mode_a_rdata_o = {key_scan_flag_o, mode_a_reg[6:0]};
  assign mode_b_rdata_o = mode_b_reg;
  assign mode_c_rdata_o = mode_c_reg;

  // configuration decode
  assign digs = mode_b_reg[`VFD_B_DIGS];
  assign running = (state_reg != vfd_st_stop);
  assign mode2 = mode_a_reg[`VFD_A_TYPE];
  assign cyc_last = mode_b_reg[`VFD_B_CYC] ? `VFD_CYC_LONG_LAST
                                            : `VFD_CYC_SHORT_LAST;
  assign cyc_term = (cyc_cnt_reg == cyc_last);

  // field value n means n+1 digits, at most 16
  assign ndig = {2'b00, digs} + 6'h01;
  // segment field counts upward from the smallest segment count
  assign nseg_raw = {1'b0, mode_a_reg[`VFD_A_SEGS]} + `VFD_SEG_BASE_COUNT;
  // digits keep their lines; segments take what is left
  assign nseg_room = 6'(`VFD_LINES) - ndig;
  assign nseg = (nseg_raw > nseg_room) ? nseg_room : nseg_raw;
  assign disp_end = {1'b0, ndig} + {1'b0, nseg};

  // the fetch always points at the digit that comes next, so its word is
  // ready at the shadow register input well before the digit switches
  always_comb begin
    if (state_reg == vfd_st_digit && digit_reg != digs) begin
      fetch_digit = digit_reg + 4'h1;
    end else begin
      fetch_digit = 4'h0;
    end
  end

  // display memory with its own fetch port
  vfd_disp_mem u_mem (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i),
    .cpu_addr_i(mem_addr_i),
    .cpu_wr_i(mem_wr_i),
    .cpu_wdata_i(mem_wdata_i),
    .cpu_rdata_o(mem_rdata_o),
    .cpu_hit_o(mem_hit_o),
    .dma_digit_i(fetch_digit),
    .dma_word_o(fetch_word)
  );

  // display cycle counter, restarted on every slot change
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cyc_cnt_reg <= 11'h000;
    end else if (clk_en_i) begin
      if (!running || cyc_term) begin
        cyc_cnt_reg <= 11'h000;
      end else begin
        cyc_cnt_reg <= cyc_cnt_reg + 11'h001;
      end
    end
  end

  // slot sequencer: blank once after start, digits, key scan, repeat
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= vfd_st_stop;
      digit_reg <= 4'h0;
    end else if (clk_en_i) begin
      if (digs == 4'h0) begin
        state_reg <= vfd_st_stop;
        digit_reg <= 4'h0;
      end else begin
        case (state_reg)
          vfd_st_stop: begin
            state_reg <= vfd_st_blank;
            digit_reg <= 4'h0;
          end
          vfd_st_blank: begin
            if (cyc_term) begin
              state_reg <= vfd_st_digit;
              digit_reg <= 4'h0;
            end
          end
          vfd_st_digit: begin
            if (cyc_term) begin
              if (digit_reg >= digs) begin
                state_reg <= vfd_st_keyscan;
                digit_reg <= 4'h0;
              end else begin
                digit_reg <= digit_reg + 4'h1;
              end
            end
          end
          vfd_st_keyscan: begin
            if (cyc_term) begin
              state_reg <= vfd_st_digit;
              digit_reg <= 4'h0;
            end
          end
          default: begin
            state_reg <= vfd_st_stop;
            digit_reg <= 4'h0;
          end
        endcase
      end
    end
  end

  // the shadow word changes only at a slot boundary, so a processor write
  // mid-digit never tears the pattern on the glass
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seg_word_reg <= 40'h00_0000_0000;
    end else if (clk_en_i && running && cyc_term) begin
      seg_word_reg <= fetch_word;
    end
  end

  // per line: pick digit, segment, pattern bit or port latch
  genvar k;
  generate
    for (k = 0; k < `VFD_LINES; k = k + 1) begin : g_line
      localparam logic [6:0] LINE_IDX = 7'(k);
      logic shared_bit;
      logic is_dig;
      logic is_seg;
      logic [6:0] seg_idx;
      logic seg_bit;
      logic pat_bit;
      logic lit;

      // lines 0 to 12 have no port behind them and idle at 0
      if (k >= `VFD_FIRST_SHARED) begin : g_shared
        assign shared_bit = port_latch_i[k];
      end else begin : g_fixed
        assign shared_bit = 1'b0;
      end

      // digits from line 0, segments right after the last digit
      assign is_dig = running && (LINE_IDX < {1'b0, ndig});
      assign is_seg = running && !is_dig && (LINE_IDX < disp_end);
      assign seg_idx = LINE_IDX - {1'b0, ndig};

      // mode 1: segment bit j of the word drives segment line j
      assign seg_bit = (seg_idx < 7'(`VFD_SEG_BITS)) ?
                       seg_word_reg[seg_idx[5:0]] : 1'b0;
      // mode 2: the word is the whole output pattern from line 0
      if (k < `VFD_SEG_BITS) begin : g_pat
        assign pat_bit = seg_word_reg[k];
      end else begin : g_nopat
        assign pat_bit = 1'b0;
      end

      always_comb begin
        if (mode2) begin
          lit = pat_bit;
        end else if (is_dig) begin
          lit = (digit_reg == 4'(k));
        end else begin
          lit = seg_bit;
        end
      end

      always_comb begin
        if (state_reg == vfd_st_keyscan) begin
          line_next[k] = shared_bit;
          disp_next[k] = 1'b0;
        end else if (is_dig || is_seg) begin
          line_next[k] = (state_reg == vfd_st_digit) ? lit : 1'b0;
          disp_next[k] = 1'b1;
        end else begin
          line_next[k] = shared_bit;
          disp_next[k] = 1'b0;
        end
      end
    end
  endgenerate

  // outputs registered; one clock behind the sequencer against a slot of
  // a thousand clocks, a lag traded for glitch-free pins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_o <= '0;
      line_is_display_o <= '0;
    end else if (clk_en_i) begin
      line_o <= line_next;
      line_is_display_o <= disp_next;
    end
  end

endmodule : vfd_output_assign
`default_nettype wire

/* verilog/vfd_pkg.sv */
`default_nettype none
package vfd_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    vfd_st_stop = 2'b00,
    vfd_st_blank = 2'b01,
    vfd_st_digit = 2'b10,
    vfd_st_keyscan = 2'b11
  } vfd_state_t;

  typedef logic [7:0] vfd_byte_t;
  typedef logic [3:0] vfd_digit_t;
  typedef logic [39:0] vfd_seg_word_t;
  typedef logic [52:0] vfd_lines_t;

endpackage : vfd_pkg
`default_nettype wire

/* verilog/vfd_regs.svh */
`ifndef VFD_REGS_SVH
`define VFD_REGS_SVH

// display data memory window
`define VFD_MEM_BASE 16'hfa30
`define VFD_MEM_LAST 16'hfa7f
`define VFD_MEM_WORDS 80

// output line layout
`define VFD_LINES 53
`define VFD_FIRST_SHARED 13
`define VFD_MAX_DIGITS 16
`define VFD_SEG_BITS 40
`define VFD_SEG_BASE_COUNT 6'h09

// mode register a fields
`define VFD_A_KSF 7
`define VFD_A_TYPE 5
`define VFD_A_SEGS 4:0
`define VFD_A_RST 8'h00

// mode register b fields
`define VFD_B_DIGS 7:4
`define VFD_B_CUT 3:1
`define VFD_B_CYC 0
`define VFD_B_RST 8'h00

// mode register c: mask bit count, six bits wide
`define VFD_C_MASK 5:0
`define VFD_C_RST 8'h00

// display cycle length in main clock periods, as terminal counts
`define VFD_CYC_SHORT 1024
`define VFD_CYC_LONG 2048
`define VFD_CYC_SHORT_LAST 11'(`VFD_CYC_SHORT - 1)
`define VFD_CYC_LONG_LAST 11'(`VFD_CYC_LONG - 1)

`endif
